// >>> logic/iprio_pkg.sv
// package for the interrupt priority register bank
// assumes a 32-bit apb slave on a single 40 MHz clock
// Notes on behaviour
// - 3-bit rw field per source, 111 is seven
// - 001 is level one, linear to seven
// - 000 disables the source entirely
// - unassigned bits ignore writes, read zero
// - reset loads every field with 100
// - first register: dma1, adc, uart1 tx
// - second register: change, comparator, i2c1 pair
// - sixth register: can pair, spi2 pair
// - can fields inert without can controller
// - seventh register: only dma3 at 2-0
// - levels 8-15 are traps, never assignable
package iprio_pkg;
  localparam int  IPRIO_NREG       = 7;           // registers in the bank
  localparam int  IPRIO_NSRC       = 23;          // priority fields in total
  localparam int  IPRIO_FW         = 3;           // field width
  localparam int  IPRIO_AW         = 12;          // decoded address bits
  localparam logic [IPRIO_AW-1:0] IPRIO_BASE = 12'h000; // first register byte address, word stride
  localparam logic [2:0]  IPRIO_RESET_LVL = 3'h4; // reset level of every field
  localparam logic [2:0]  IPRIO_OFF       = 3'h0; // disabled code
  localparam logic [3:0]  IPRIO_TRAP_MIN  = 4'h8; // first trap level
  // implemented-bit masks per register
  localparam logic [15:0] IPRIO_MASK [IPRIO_NREG] = '{
    16'h0777, 16'h7777, 16'h7707, 16'h7777, 16'h7777, 16'h7777, 16'h0007};
  // lsb position of each field and its register
  localparam int IPRIO_SRC_REG [IPRIO_NSRC] = '{
    0,0,0, 1,1,1,1, 2,2,2, 3,3,3,3, 4,4,4,4, 5,5,5,5, 6};
  localparam int IPRIO_SRC_LSB [IPRIO_NSRC] = '{
    8,4,0, 12,8,4,0, 12,8,0, 12,8,4,0, 12,8,4,0, 12,8,4,0, 0};
  // source indices of the can fields
  localparam int IPRIO_CAN_EV = 18;
  localparam int IPRIO_CAN_RX = 19;
endpackage

// >>> logic/iprio_field_if.sv
// interface carrying the field values to the level mapper
// assumes same clock as the register bank
`timescale 1ns/10ps
interface iprio_field_if;
  logic [2:0] field  [23];  // raw field values
  logic [3:0] level  [23];  // effective levels, 0 when disabled
  modport bank   (output field, input level);
  modport mapper (input field, output level);
endinterface

// >>> logic/iprio_level_map.sv
// maps raw priority fields to effective arbitration levels
// assumes can_present is a static strap from the same clock domain
`timescale 1ns/10ps
module iprio_level_map
  import iprio_pkg::*;
(
  iprio_field_if.mapper fld,
  input  wire logic     can_present_in
);
  ////////////////////////////////////////////////////////////
  // per source level, one generate loop
  genvar g;
  generate
    for (g = 0; g < IPRIO_NSRC; g++) begin : g_src
      logic inert;  // can field on a variant without can
      assign inert = ((g == IPRIO_CAN_EV) || (g == IPRIO_CAN_RX)) && !can_present_in;
      // 000 disables, 001..111 linear 1..7, never a trap level
      assign fld.level[g] = (inert || fld.field[g] == IPRIO_OFF) ? 4'h0 : {1'b0, fld.field[g]};
    end
  endgenerate
endmodule

// >>> logic/iprio_regs.sv
// apb register bank of interrupt priority fields
// assumes an apb master on core_clk_in, 32-bit data
`timescale 1ns/10ps
module iprio_regs
  import iprio_pkg::*;
(
  input  wire logic                core_clk_in,
  input  wire logic                rst_b_in,
  input  wire logic                clk_en_in,
  input  wire logic                can_present_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [IPRIO_AW-1:0] paddr_in,
  input  wire logic [31:0]         pwdata_in,
  input  wire logic [3:0]          pstrb_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  output logic      [3:0]          src_level_out [IPRIO_NSRC]
);
  ////////////////////////////////////////////////////////////
  // storage
  logic [15:0] reg_ff [IPRIO_NREG];  // priority registers
  logic [31:0] prdata_ff;            // registered read data
  logic        pslverr_ff;           // registered error
  logic [3:0]  level_ff [IPRIO_NSRC];// registered levels
  logic        hit;                  // address inside the bank
  logic [2:0]  idx;                  // register index
  logic        access;               // access phase
  iprio_field_if fld ();

  assign access = psel_in && penable_in;
  assign idx    = paddr_in[4:2];
  assign hit    = (paddr_in[IPRIO_AW-1:5] == IPRIO_BASE[IPRIO_AW-1:5]) && (paddr_in[1:0] == 2'h0)
                  && (idx < 3'(IPRIO_NREG));
  assign pready_out  = 1'b1;  // zero wait states
  assign prdata_out  = prdata_ff;
  assign pslverr_out = pslverr_ff;

  ////////////////////////////////////////////////////////////
  // register writes, masked to implemented bits
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      for (int r = 0; r < IPRIO_NREG; r++) begin
        // every field starts at level four
        reg_ff[r] <= {4{1'b0, IPRIO_RESET_LVL}} & IPRIO_MASK[r];
      end
    end else if (clk_en_in && access && pwrite_in && hit) begin
      for (int r = 0; r < IPRIO_NREG; r++) begin
        if (idx == 3'(r)) begin
          // byte lanes 0 and 1 only; upper lanes have no storage
          if (pstrb_in[0]) reg_ff[r][7:0]  <= pwdata_in[7:0]  & IPRIO_MASK[r][7:0];
          if (pstrb_in[1]) reg_ff[r][15:8] <= pwdata_in[15:8] & IPRIO_MASK[r][15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // read data and error, registered in the setup cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (psel_in && !penable_in) begin
        // unused bits and upper half read zero
        prdata_ff  <= (hit && !pwrite_in) ? {16'h0000, reg_ff[idx] & IPRIO_MASK[idx]} : 32'h0000_0000;
        pslverr_ff <= !hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // field extraction in the documented layouts
  genvar g;
  generate
    for (g = 0; g < IPRIO_NSRC; g++) begin : g_fld
      assign fld.field[g] = reg_ff[IPRIO_SRC_REG[g]][IPRIO_SRC_LSB[g] +: IPRIO_FW];
    end
  endgenerate

  iprio_level_map u_map (
    .fld            (fld),
    .can_present_in (can_present_in)
  );

  ////////////////////////////////////////////////////////////
  // registered levels toward the arbiter
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      for (int s = 0; s < IPRIO_NSRC; s++) level_ff[s] <= 4'h0;
    end else if (clk_en_in) begin
      for (int s = 0; s < IPRIO_NSRC; s++) level_ff[s] <= fld.level[s];
    end
  end
  assign src_level_out = level_ff;

  ////////////////////////////////////////////////////////////
  // checks
  a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (reg_ff[6] & ~IPRIO_MASK[6]) == 16'h0000 && (reg_ff[0] & ~IPRIO_MASK[0]) == 16'h0000)
    else $error("unused bits hold ones");
  a_reset_four: assert property (@(posedge core_clk_in)
    !rst_b_in ##1 rst_b_in |-> reg_ff[1] == 16'h4444 && reg_ff[6] == 16'h0004)
    else $error("reset value wrong");
  a_disable_zero: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    clk_en_in && fld.field[0] == IPRIO_OFF |=> level_ff[0] == 4'h0)
    else $error("disabled source has level");
  a_linear_map: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    clk_en_in && fld.field[3] != IPRIO_OFF |=> level_ff[3] == {1'b0, $past(fld.field[3])})
    else $error("level mismatch");
  a_no_trap: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    level_ff[5] < IPRIO_TRAP_MIN && level_ff[22] < IPRIO_TRAP_MIN)
    else $error("trap level assigned");
  a_can_inert: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    clk_en_in && !can_present_in |=> level_ff[IPRIO_CAN_EV] == 4'h0)
    else $error("can field active without can");
  a_write_lands: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    clk_en_in && access && pwrite_in && hit && idx == 3'h3 && pstrb_in == 4'hF
    |=> reg_ff[3] == ($past(pwdata_in[15:0]) & IPRIO_MASK[3]))
    else $error("write lost");
  a_dma3_field: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    fld.field[22] == reg_ff[6][2:0])
    else $error("dma3 field misplaced");
  a_read_back: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    clk_en_in && psel_in && !penable_in && !pwrite_in && hit && idx == 3'h0
    |=> prdata_ff[31:11] == 21'h0 && prdata_ff[7] == 1'b0)
    else $error("readback unused bits set");
  c_write: cover property (@(posedge core_clk_in) access && pwrite_in && hit);
  c_read:  cover property (@(posedge core_clk_in) access && !pwrite_in && hit);
  c_err:   cover property (@(posedge core_clk_in) access && !hit);
  c_off:   cover property (@(posedge core_clk_in) level_ff[0] == 4'h0);
endmodule

// >>> dv/iprio_arb_model.sv
// far-side model: arbitration picks the highest enabled level
// assumes levels arrive already mapped, 0 meaning disabled
`timescale 1ns/10ps
module iprio_arb_model (
  input  wire logic [3:0] lvl_in [23],
  output logic      [3:0] top_out
);
  // highest level wins, a disabled source never wins
  always_comb begin
    top_out = 4'h0;
    for (int i = 0; i < 23; i++) begin
      if (lvl_in[i] > top_out) begin
        top_out = lvl_in[i];
      end
    end
  end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the priority register bank
// assumes an apb slave answering with pready and one clock
`timescale 1ns/10ps
module tb_top;
  import iprio_pkg::*;
  logic        clk = 0, rst_b = 0, can = 1, psel = 0, pen = 0, pwr = 0, ce = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        prdy, perr, e;
  logic [3:0]  lvl [IPRIO_NSRC];
  logic [3:0]  top;
  logic [15:0] m [IPRIO_NREG];  // expected register contents
  int          n_fail = 0, num_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;      // 40 MHz
  iprio_regs i_iprio_regs (.core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(ce),
    .can_present_in(can), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwd), .pstrb_in(4'hF), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .src_level_out(lvl));
  iprio_arb_model i_iprio_arb_model (.lvl_in(lvl), .top_out(top));
  ////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    e = perr;
    psel <= 0; pen <= 0;
    @(posedge clk);  // idle edge so the next call never reassigns in this step
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    num_checks++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", n, x, s);
    end
  endtask
  // expected level of one source from the model registers
  function logic [3:0] lv(int s);
    if (!can && (s == IPRIO_CAN_EV || s == IPRIO_CAN_RX)) return 4'h0;
    return {1'b0, m[IPRIO_SRC_REG[s]][IPRIO_SRC_LSB[s]+:3]};
  endfunction
  task chk_lvl;
    logic [3:0] t;
    t = 4'h0;
    @(posedge clk);
    #1;
    for (int s = 0; s < IPRIO_NSRC; s++) begin
      chk("level", lv(s), lvl[s]);
      if (lv(s) > t) t = lv(s);
    end
    chk("top", t, top);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(37));
    repeat (5) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    // reset image read back
    for (int r = 0; r < IPRIO_NREG; r++) begin
      m[r] = IPRIO_MASK[r] & 16'h4444;
      apb(0, IPRIO_BASE + 12'(r * 4), 32'h0);
      chk("reset", {16'h0, m[r]}, rd);
    end
    chk_lvl;
    $display("test reset done");
    // zeros, ones, then random images, can fitted or not
    for (int i = 0; i < 49; i++) begin
      int r;
      logic [31:0] d;
      r = i % 7;
      d = (i < 7) ? 32'h0 : (i < 14) ? 32'hFFFFFFFF : $urandom;
      can <= (i < 14) ? 1'b1 : 1'($urandom);
      m[r] = d[15:0] & IPRIO_MASK[r];
      apb(1, IPRIO_BASE + 12'(r * 4), d);
      apb(0, IPRIO_BASE + 12'(r * 4), 32'h0);
      chk("data", {16'h0, m[r]}, rd);
      chk_lvl;
    end
    $display("test write read done");
    // frozen clock enable drops a write
    ce <= 0;
    apb(1, IPRIO_BASE, {16'h0000, ~m[0]});
    ce <= 1;
    apb(0, IPRIO_BASE, 32'h0);
    chk("frozen", {16'h0, m[0]}, rd);
    $display("test clock enable done");
    // unmapped places refuse and leave the bank alone
    foreach (m[k]) begin
      apb(1, 12'h01C + 12'(k * 2), 32'hFFFFFFFF);
      chk("werr", 32'h1, {31'h0, e});
      apb(0, 12'h01C + 12'(k * 2), 32'h0);
      chk("rerr", 32'h1, {31'h0, e});
      chk("rdata", 32'h0, rd);
    end
    chk_lvl;
    $display("test unmapped done");
    end_of_test;
  end
endmodule
